// File: verilog/pdci_pkg.sv
// pdci_pkg: register map, widths and reset values of the parallel i/o data and pin change block
// assumes a 32-bit avalon-mm slave port with byte addressing
package pdci_pkg;
  localparam int unsigned PDCI_LINES = 32;
  localparam int unsigned PDCI_ADDR_W = 8;
  localparam int unsigned PDCI_DATA_W = 32;
  localparam int unsigned PDCI_SYNC_STAGES = 2;

  // byte offsets of the registers
  localparam logic [7:0] PDCI_FILTER_SELECT_ON = 8'h20;
  localparam logic [7:0] PDCI_FILTER_SELECT_OFF = 8'h24;
  localparam logic [7:0] PDCI_FILTER_SELECT_STATUS = 8'h28;
  localparam logic [7:0] PDCI_OUTPUT_DATA_SET = 8'h30;
  localparam logic [7:0] PDCI_OUTPUT_DATA_CLEAR = 8'h34;
  localparam logic [7:0] PDCI_OUTPUT_DATA_READBACK = 8'h38;
  localparam logic [7:0] PDCI_PIN_LEVEL_READBACK = 8'h3C;
  localparam logic [7:0] PDCI_CHANGE_IRQ_ENABLE = 8'h40;
  localparam logic [7:0] PDCI_CHANGE_IRQ_DISABLE = 8'h44;
  localparam logic [7:0] PDCI_CHANGE_IRQ_MASK = 8'h48;
  localparam logic [7:0] PDCI_PIN_CHANGE_STATUS = 8'h4C;

  // values after reset
  localparam logic [31:0] PDCI_FILTER_RESET = 32'h0000_0000;
  localparam logic [31:0] PDCI_OUTPUT_DATA_RESET = 32'h0000_0000;
  localparam logic [31:0] PDCI_MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] PDCI_STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] PDCI_SYNC_RESET = 32'h0000_0000;
  localparam logic [31:0] PDCI_UNMAPPED_READ = 32'h0000_0000;

  // bus answer state
  typedef enum logic [0:0] {
    PDCI_IDLE,
    PDCI_ANSWER
  } pdci_bus_state_t;
endpackage

// File: verilog/pdci_line_sync.sv
// pdci_line_sync: two-flop synchroniser per pin plus a change detector on the settled level
// assumes pins are asynchronous to clock; the first stage feeds only the second
`timescale 1ns/1ps
module pdci_line_sync #(
  parameter int unsigned WIDTH = 32
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // raw pins
  input wire logic [WIDTH-1:0] pin_raw,
  // settled level and one-cycle change pulses
  output logic [WIDTH-1:0] pin_level,
  output logic [WIDTH-1:0] pin_change
);
  import pdci_pkg::*;

  logic [WIDTH-1:0] stage_one;
  logic [WIDTH-1:0] stage_two;
  logic [WIDTH-1:0] stage_prev;

  // synchroniser chain and previous settled level
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stage_one <= PDCI_SYNC_RESET[WIDTH-1:0];
      stage_two <= PDCI_SYNC_RESET[WIDTH-1:0];
      stage_prev <= PDCI_SYNC_RESET[WIDTH-1:0];
    end else begin
      stage_one <= pin_raw;
      stage_two <= stage_one;
      stage_prev <= stage_two;
    end
  end

  // any rising or falling edge of the settled level
  assign pin_level = stage_two;
  assign pin_change = stage_two ^ stage_prev;
endmodule

// File: verilog/pdci_port.sv
// pdci_port: output data, pin readback, filter selection and pin change interrupt of a 32-line i/o port
// assumes line ownership and direction come from the lower half on the same clock
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module pdci_port #(
  parameter int unsigned LINES = pdci_pkg::PDCI_LINES
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // avalon-mm slave
  input wire logic [pdci_pkg::PDCI_ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [pdci_pkg::PDCI_DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [pdci_pkg::PDCI_DATA_W-1:0] readdata,
  output logic waitrequest,
  // line states from the lower half
  input wire logic [LINES-1:0] line_ownership_status,
  input wire logic [LINES-1:0] line_direction_status,
  // pins
  input wire logic [LINES-1:0] io_line_in,
  output logic [LINES-1:0] io_line_out,
  output logic [LINES-1:0] io_line_oe_n,
  // filter selection to the filter circuit
  output logic [LINES-1:0] filter_select,
  // interrupt request
  output logic irq
);
  import pdci_pkg::*;

  pdci_bus_state_t bus_state;
  pdci_bus_state_t next_bus_state;

  logic [LINES-1:0] filter_select_status;
  logic [LINES-1:0] output_data;
  logic [LINES-1:0] change_irq_mask;
  logic [LINES-1:0] pin_change_status;
  logic [LINES-1:0] pin_level;
  logic [LINES-1:0] pin_change;
  logic [LINES-1:0] io_out_reg;

  logic [LINES-1:0] next_filter_select_status;
  logic [LINES-1:0] next_output_data;
  logic [LINES-1:0] next_change_irq_mask;
  logic [LINES-1:0] next_pin_change_status;
  logic [PDCI_DATA_W-1:0] next_readdata;

  wire request;
  wire take_read;
  wire take_write;
  wire [PDCI_DATA_W-1:0] byte_mask;
  wire [LINES-1:0] wmask;
  wire hit_filter_on;
  wire hit_filter_off;
  wire hit_filter_status;
  wire hit_set;
  wire hit_clear;
  wire hit_odata;
  wire hit_level;
  wire hit_irq_on;
  wire hit_irq_off;
  wire hit_mask;
  wire hit_status;
  wire [LINES-1:0] line_drives;
  wire [LINES-1:0] status_read_clear;
  wire [LINES-1:0] status_write_clear;
  wire [PDCI_DATA_W-1:0] read_mux;

  // pin synchroniser and edge detector
  pdci_line_sync #(
    .WIDTH(LINES)
  ) u_line_sync (
    .clock(clock),
    .nrst(nrst),
    .pin_raw(io_line_in),
    .pin_level(pin_level),
    .pin_change(pin_change)
  );

  // bus handshake: one wait cycle, answer in the second
  assign request = read | write;
  assign waitrequest = request & (bus_state == PDCI_IDLE);
  assign take_read = read & (bus_state == PDCI_IDLE);
  assign take_write = write & (bus_state == PDCI_ANSWER);

  // byte lanes widened to a bit mask
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
      assign byte_mask[lane*8 +: 8] = {8{byteenable[lane]}};
    end
  endgenerate
  assign wmask = writedata[LINES-1:0] & byte_mask[LINES-1:0];

  // address decode
  assign hit_filter_on = (address == PDCI_FILTER_SELECT_ON);
  assign hit_filter_off = (address == PDCI_FILTER_SELECT_OFF);
  assign hit_filter_status = (address == PDCI_FILTER_SELECT_STATUS);
  assign hit_set = (address == PDCI_OUTPUT_DATA_SET);
  assign hit_clear = (address == PDCI_OUTPUT_DATA_CLEAR);
  assign hit_odata = (address == PDCI_OUTPUT_DATA_READBACK);
  assign hit_level = (address == PDCI_PIN_LEVEL_READBACK);
  assign hit_irq_on = (address == PDCI_CHANGE_IRQ_ENABLE);
  assign hit_irq_off = (address == PDCI_CHANGE_IRQ_DISABLE);
  assign hit_mask = (address == PDCI_CHANGE_IRQ_MASK);
  assign hit_status = (address == PDCI_PIN_CHANGE_STATUS);

  // read selection; write-only and unmapped offsets read zero
  assign read_mux =
    hit_filter_status ? PDCI_DATA_W'(filter_select_status) :
    hit_odata ? PDCI_DATA_W'(output_data) :
    hit_level ? PDCI_DATA_W'(pin_level) :
    hit_mask ? PDCI_DATA_W'(change_irq_mask) :
    hit_status ? PDCI_DATA_W'(pin_change_status) :
    PDCI_UNMAPPED_READ;

  // status clears: on the read that samples it, or ones written to it
  assign status_read_clear = {LINES{take_read & hit_status}};
  assign status_write_clear = (take_write & hit_status) ? wmask : '0;

  // bus state sequencing
  always_comb begin
    next_bus_state = bus_state;
    case (bus_state)
      PDCI_IDLE: begin
        if (request) begin
          next_bus_state = PDCI_ANSWER;
        end
      end
      PDCI_ANSWER: begin
        next_bus_state = PDCI_IDLE;
      end
      default: begin
        next_bus_state = PDCI_IDLE;
      end
    endcase
  end

  // read data captured on the first edge and held through the answer cycle
  always_comb begin
    next_readdata = readdata;
    if (take_read) begin
      next_readdata = read_mux;
    end
  end

  // filter selection, set by on writes, cleared by off writes
  always_comb begin
    next_filter_select_status = filter_select_status;
    if (take_write & hit_filter_on) begin
      next_filter_select_status = filter_select_status | wmask;
    end
    if (take_write & hit_filter_off) begin
      next_filter_select_status = filter_select_status & ~wmask;
    end
  end

  // output data, set and clear by ones only
  always_comb begin
    next_output_data = output_data;
    if (take_write & hit_set) begin
      next_output_data = output_data | wmask;
    end
    if (take_write & hit_clear) begin
      next_output_data = output_data & ~wmask;
    end
  end

  // interrupt mask, enable and disable by ones only
  always_comb begin
    next_change_irq_mask = change_irq_mask;
    if (take_write & hit_irq_on) begin
      next_change_irq_mask = change_irq_mask | wmask;
    end
    if (take_write & hit_irq_off) begin
      next_change_irq_mask = change_irq_mask & ~wmask;
    end
  end

  // change status: a new edge wins over any clear in the same cycle
  always_comb begin
    next_pin_change_status = (pin_change_status & ~status_read_clear & ~status_write_clear)
      | pin_change;
  end

  // bus registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bus_state <= PDCI_IDLE;
      readdata <= PDCI_UNMAPPED_READ;
    end else begin
      bus_state <= next_bus_state;
      readdata <= next_readdata;
    end
  end

  // configuration and data registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      filter_select_status <= PDCI_FILTER_RESET[LINES-1:0];
      output_data <= PDCI_OUTPUT_DATA_RESET[LINES-1:0];
      change_irq_mask <= PDCI_MASK_RESET[LINES-1:0];
    end else begin
      filter_select_status <= next_filter_select_status;
      output_data <= next_output_data;
      change_irq_mask <= next_change_irq_mask;
    end
  end

  // change status register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pin_change_status <= PDCI_STATUS_RESET[LINES-1:0];
    end else begin
      pin_change_status <= next_pin_change_status;
    end
  end

  // pin data register, a copy of the stored output data
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      io_out_reg <= PDCI_OUTPUT_DATA_RESET[LINES-1:0];
    end else begin
      io_out_reg <= next_output_data;
    end
  end

  // drive only lines owned by the port and set as outputs
  assign line_drives = line_ownership_status & line_direction_status;
  assign io_line_oe_n = ~line_drives;
  assign io_line_out = io_out_reg;

  // filter selection handed to the filter circuit
  assign filter_select = filter_select_status;

  // level interrupt from unmasked change status
  assign irq = |(pin_change_status & change_irq_mask);
endmodule

// File: tb/pdci_port_props.sv
// pdci_port_props: timing checks on the ports of pdci_port
// assumes byteenable is all ones on every write
`timescale 1ns/1ps
module pdci_port_props #(
  parameter int unsigned LINES = 32
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // bus
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // lines
  input wire logic [LINES-1:0] line_ownership_status,
  input wire logic [LINES-1:0] line_direction_status,
  input wire logic [LINES-1:0] io_line_in,
  input wire logic [LINES-1:0] io_line_out,
  input wire logic [LINES-1:0] io_line_oe_n,
  input wire logic [LINES-1:0] filter_select,
  input wire logic irq
);
  // accepted write and read
  wire acc_w = write && !waitrequest;
  wire acc_r = read && !waitrequest;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_oe; io_line_oe_n == ~(line_ownership_status & line_direction_status); endproperty
  a_oe: assert property (p_oe) else $error("oe wrong");
  property p_set; acc_w && address == 8'h30 |=> (io_line_out & $past(writedata)) == $past(writedata); endproperty
  a_set: assert property (p_set) else $error("set lost");
  property p_clr; acc_w && address == 8'h34 |=> (io_line_out & $past(writedata)) == 32'h0; endproperty
  a_clr: assert property (p_clr) else $error("clear lost");
  property p_irqd; acc_w && address == 8'h44 && writedata == 32'hFFFFFFFF |=> !irq; endproperty
  a_irqd: assert property (p_irqd) else $error("irq after disable");
  property p_pdsr; acc_r && address == 8'h3C |-> readdata == $past(io_line_in, 3); endproperty
  a_pdsr: assert property (p_pdsr) else $error("pin level wrong");
  property p_odsr; acc_r && address == 8'h38 |-> readdata == io_line_out; endproperty
  a_odsr: assert property (p_odsr) else $error("output data wrong");
  property p_rst; $rose(nrst) |-> !irq && filter_select == 32'h0 && io_line_out == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("reset value");
  property p_filt; $changed(filter_select) |-> $past(acc_w && (address == 8'h20 || address == 8'h24)); endproperty
  a_filt: assert property (p_filt) else $error("filter moved");
endmodule
bind pdci_port pdci_port_props #(.LINES(LINES)) u_props (.clock, .nrst, .address, .read, .write, .writedata,
  .readdata, .waitrequest, .line_ownership_status, .line_direction_status, .io_line_in, .io_line_out,
  .io_line_oe_n, .filter_select, .irq);

// File: tb/pdci_pin_model.sv
// pdci_pin_model: the pads, driven by the port or by the outside world
// assumes the outside drives every line that the port releases
`timescale 1ns/1ps
module pdci_pin_model (
  // port side
  input wire logic [31:0] drive,
  input wire logic [31:0] drive_oe_n,
  // outside level and pad
  input wire logic [31:0] outside,
  output logic [31:0] pin
);
  // port wins where enabled
  assign pin = (drive & ~drive_oe_n) | (outside & drive_oe_n);
endmodule

// File: tb/testbench.sv
// testbench: random register and pin traffic on pdci_port against a bench model
// assumes one access at a time and pins settled before status reads
`timescale 1ns/1ps
module testbench;
  logic clock = 0;
  logic nrst = 0;
  logic read = 0;
  logic write = 0;
  logic [7:0] address = 8'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] own = 32'h0;
  logic [31:0] dir = 32'h0;
  logic [31:0] ext = 32'h0;
  logic [31:0] readdata, io_line_in, io_line_out, io_line_oe_n, filter_select;
  logic waitrequest, irq;
  logic [31:0] seed = 32'hFD49;
  logic [31:0] od = 0, filt = 0, mask = 0, stat = 0, last = 0, q;
  logic [31:0] exp_v[4];
  logic [7:0] rd_regs[4] = '{8'h28, 8'h38, 8'h48, 8'h3C};
  logic [7:0] ops[8] = '{8'h30, 8'h34, 8'h20, 8'h24, 8'h40, 8'h44, 8'h48, 8'h50};
  logic [7:0] zero_regs[7] = '{8'h28, 8'h38, 8'h48, 8'h4C, 8'h3C, 8'h30, 8'h50};
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  always #4 clock = ~clock;
  pdci_port u_dut (.clock, .nrst, .address, .read, .write, .writedata, .byteenable(4'hF), .readdata,
    .waitrequest, .line_ownership_status(own), .line_direction_status(dir), .io_line_in, .io_line_out,
    .io_line_oe_n, .filter_select, .irq);
  pdci_pin_model u_pins (.drive(io_line_out), .drive_oe_n(io_line_oe_n), .outside(ext), .pin(io_line_in));
  // lfsr random source
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // one avalon access, held until waitrequest is low
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    write <= w;
    read <= !w;
    address <= a;
    writedata <= d;
    do @(posedge clock); while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clock);
  endtask
  // let pins settle, then record changes
  task automatic settle();
    logic [31:0] eff;
    repeat (4) @(posedge clock);
    eff = (own & dir & od) | (~(own & dir) & ext);
    stat |= eff ^ last;
    last = eff;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
    case (a)
      8'h30: od |= d;
      8'h34: od &= ~d;
      8'h20: filt |= d;
      8'h24: filt &= ~d;
      8'h40: mask |= d;
      8'h44: mask &= ~d;
      8'h4C: stat &= ~d;
      default: ;
    endcase
    settle();
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // hang ceiling
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  // main sequence
  initial begin
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    foreach (zero_regs[i]) begin
      acc(1'b0, zero_regs[i], 32'h0);
      chk(q, 32'h0);
    end
    for (int i = 0; i < 12; i++) begin
      own <= rnd();
      dir <= rnd();
      ext <= rnd();
      settle();
      foreach (ops[j]) wr(ops[j], rnd());
      chk(io_line_out, od);
      chk(io_line_oe_n, ~(own & dir));
      chk(filter_select, filt);
      exp_v = '{filt, od, mask, last};
      foreach (rd_regs[j]) begin
        acc(1'b0, rd_regs[j], 32'h0);
        chk(q, exp_v[j]);
      end
      chk({31'h0, irq}, {31'h0, |(stat & mask)});
      acc(1'b0, 8'h4C, 32'h0);
      chk(q, stat);
      stat = 32'h0;
      acc(1'b0, 8'h4C, 32'h0);
      chk(q, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    wr(8'h44, 32'hFFFFFFFF);
    own <= 32'h0;
    ext <= ~ext;
    settle();
    chk({31'h0, irq}, 32'h0);
    wr(8'h40, 32'hFFFFFFFF);
    chk({31'h0, irq}, {31'h0, |stat});
    wr(8'h4C, 32'h0000FFFF);
    acc(1'b0, 8'h4C, 32'h0);
    chk(q, stat);
    end_of_test();
  end
endmodule
